// File: inc/pfs_consts.svh
// constants for the program flash self-write block
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// register byte offsets
`define PFS_OFS_CTRL 6'h00
`define PFS_OFS_ROW_LO 6'h04
`define PFS_OFS_ROW_HI 6'h08
`define PFS_OFS_KEY 6'h0C
`define PFS_OFS_PAGE 6'h10
`define PFS_OFS_EA 6'h14
`define PFS_OFS_TDATA_LO 6'h18
`define PFS_OFS_TDATA_HI 6'h1C
`define PFS_OFS_STATUS 6'h20

// control register fields
`define PFS_CTRL_WR 15
`define PFS_CTRL_WREN 14
`define PFS_CTRL_WRERR 13
`define PFS_CTRL_OP_MSB 6
`define PFS_CTRL_RESET 16'h0000

// operation codes
`define PFS_OP_ERASE_ROW 7'h41
`define PFS_OP_PROG_ROW 7'h01

// unlock key values
`define PFS_KEY_FIRST 8'h55
`define PFS_KEY_SECOND 8'hAA

// array geometry
`define PFS_ROW_WORDS 32
`define PFS_ROWS_PER_PANEL 128
`define PFS_PANELS 1
`define PFS_WORD_BITS 24
`define PFS_ERASED_WORD 24'hFF_FFFF

// table write latch fill, in clocks
`define PFS_LATCH_CYCLES 2

// operation time and clock period
`define PFS_OP_TIME_NS 2000000
`define PFS_CLK_PERIOD_NS 40

`define PFS_FIFO_DEPTH 8

`endif

// File: inc/pfs_pkg.sv
// types shared by the program flash self-write block
`default_nettype none
package pfs_pkg;
	typedef logic [5:0] pfs_addr_t;
	typedef logic [31:0] pfs_bus_word_t;
	typedef enum logic [1:0] {key_locked, key_half, key_armed} pfs_key_t;
	typedef enum logic [1:0] {op_idle, op_run, op_apply} pfs_op_state_t;
endpackage
`default_nettype wire

// File: core/pfs_fifo.sv
// synchronous valid/ready fifo built from flip-flops
`timescale 1ns/1ns
`default_nettype none
module pfs_fifo #(
	parameter int WIDTH = 42,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_chk
			$error("pfs_fifo: DEPTH must be a power of two >= 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wr_ptr;
	logic [PW:0] rd_ptr;
	logic full;
	logic empty;

	assign empty = (wr_ptr == rd_ptr);
	assign full = (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]) &&
		(wr_ptr[PW] != rd_ptr[PW]);
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[rd_ptr[PW-1:0]];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
		end else if (in_valid_i && !full) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (in_valid_i && !full) begin
			mem[wr_ptr[PW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_ptr <= '0;
		end else if (out_ready_i && !empty) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: core/pfs_flash.sv
// program flash self-write sequencer with table access and row latches
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "pfs_consts.svh"
module pfs_flash #(
	parameter int ROWS_PER_PANEL = `PFS_ROWS_PER_PANEL,
	parameter int PANELS = `PFS_PANELS,
	parameter int FIFO_DEPTH = `PFS_FIFO_DEPTH,
	parameter int OP_CYCLES = `PFS_OP_TIME_NS / `PFS_CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// avalon-mm slave
	input wire pfs_pkg::pfs_addr_t avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire pfs_pkg::pfs_bus_word_t avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output pfs_pkg::pfs_bus_word_t avs_readdata_o,
	output logic avs_waitrequest_o,
	// stall towards the core
	output logic flash_busy_o
);
	import pfs_pkg::*;

	localparam int RW = `PFS_ROW_WORDS;
	localparam int WB = `PFS_WORD_BITS;
	localparam int WORDS = PANELS * ROWS_PER_PANEL * RW;
	localparam int AW = $clog2(WORDS);
	localparam int PW = $clog2(ROWS_PER_PANEL * RW);
	localparam int LW = PANELS * RW;
	localparam int LAW = $clog2(LW);
	localparam int CW = $clog2(OP_CYCLES + 1);
	localparam int FW = 19 + 23;
	// a literal cannot be bit-selected, so the reset word gets a name
	localparam logic [15:0] CTRL_RST = `PFS_CTRL_RESET;

	generate
		if ((1 << $clog2(ROWS_PER_PANEL)) != ROWS_PER_PANEL ||
			PANELS < 1 || OP_CYCLES < 1 || WORDS > (1 << 23)) begin : g_chk
			$error("pfs_flash: unsupported geometry or timing");
		end
	endgenerate

	// word index from a 24-bit byte-style program address
	function automatic logic [22:0] word_of(input logic [23:0] a);
		return a[23:1];
	endfunction

	function automatic logic in_range(input logic [22:0] w);
		return w < 23'(WORDS);
	endfunction

	// latch slot: panel number above the in-row word position
	function automatic logic [LAW-1:0] latch_of(input logic [22:0] w);
		logic [22:0] panel;
		panel = w >> PW;
		return LAW'({panel, w[4:0]});
	endfunction

	// storage
	logic [WB-1:0] flash_array [WORDS];
	logic [WB-1:0] wr_latch [LW];

	// registers
	logic ctrl_wr;
	logic ctrl_wren;
	logic ctrl_wrerr;
	logic [`PFS_CTRL_OP_MSB:0] ctrl_op;
	logic [15:0] row_lo;
	logic [7:0] row_hi;
	logic [7:0] table_page;
	logic [15:0] table_ea;
	pfs_key_t key_state;

	// operation sequencer
	pfs_op_state_t op_state;
	logic [CW-1:0] op_cnt;
	logic op_erase;
	logic [22:0] op_base;
	logic [22:0] row_word;

	// bus handshake
	logic wait_q;
	logic req;
	logic can_ack;
	logic ack_now;
	logic wr_ack;
	logic rd_ack;
	logic [5:0] ofs;
	logic [23:0] tbl_addr;
	logic [22:0] tbl_word;
	logic start_req;
	logic start_ok;

	// fifo and latch writer
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [FW-1:0] fifo_in_data;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [FW-1:0] fifo_out_data;
	logic fill_phase;
	logic drain_idle;

	assign ofs = {avs_address_i[5:2], 2'b00};
	assign tbl_addr = {table_page, table_ea};
	assign tbl_word = word_of(tbl_addr);
	assign row_word = word_of({row_hi, row_lo});
	assign req = avs_read_i || avs_write_i;
	assign start_req = avs_write_i && (ofs == `PFS_OFS_CTRL) &&
		avs_byteenable_i[1] && avs_writedata_i[`PFS_CTRL_WR];
	assign drain_idle = !fifo_out_valid && !fill_phase;
	assign start_ok = (key_state == key_armed) &&
		avs_writedata_i[`PFS_CTRL_WREN] &&
		(avs_writedata_i[`PFS_CTRL_OP_MSB:0] == `PFS_OP_ERASE_ROW ||
		avs_writedata_i[`PFS_CTRL_OP_MSB:0] == `PFS_OP_PROG_ROW);

	// hold off while an operation runs; a start waits for the latches
	always_comb begin
		can_ack = 1'b1;
		if (op_state != op_idle) begin
			can_ack = 1'b0;
		end else if (avs_write_i && (ofs == `PFS_OFS_TDATA_LO ||
			ofs == `PFS_OFS_TDATA_HI)) begin
			can_ack = fifo_in_ready;
		end else if (start_req) begin
			can_ack = drain_idle;
		end
	end

	assign ack_now = req && wait_q && can_ack;
	assign wr_ack = ack_now && avs_write_i;
	assign rd_ack = ack_now && avs_read_i;

	// table writes stage in the fifo; the array is never touched here
	assign fifo_in_valid = wr_ack && (ofs == `PFS_OFS_TDATA_LO ||
		ofs == `PFS_OFS_TDATA_HI);
	assign fifo_in_data = {tbl_word, (ofs == `PFS_OFS_TDATA_HI),
		avs_byteenable_i[1:0], avs_writedata_i[15:0]};

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !ack_now;
		end
	end

	// register and table read path
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_readdata_o <= '0;
		end else if (rd_ack) begin
			avs_readdata_o <= '0;
			case (ofs)
				`PFS_OFS_CTRL: begin
					avs_readdata_o[`PFS_CTRL_WR] <= ctrl_wr;
					avs_readdata_o[`PFS_CTRL_WREN] <= ctrl_wren;
					avs_readdata_o[`PFS_CTRL_WRERR] <= ctrl_wrerr;
					avs_readdata_o[`PFS_CTRL_OP_MSB:0] <= ctrl_op;
				end
				`PFS_OFS_ROW_LO: avs_readdata_o[15:0] <= row_lo;
				`PFS_OFS_ROW_HI: avs_readdata_o[7:0] <= row_hi;
				`PFS_OFS_PAGE: avs_readdata_o[7:0] <= table_page;
				`PFS_OFS_EA: avs_readdata_o[15:0] <= table_ea;
				`PFS_OFS_TDATA_LO: begin
					if (in_range(tbl_word)) begin
						avs_readdata_o[15:0] <=
							flash_array[AW'(tbl_word)][15:0];
					end
				end
				`PFS_OFS_TDATA_HI: begin
					if (in_range(tbl_word)) begin
						avs_readdata_o[7:0] <=
							flash_array[AW'(tbl_word)][23:16];
					end
				end
				`PFS_OFS_STATUS: begin
					avs_readdata_o[0] <= !drain_idle;
					avs_readdata_o[1] <= !fifo_in_ready;
					avs_readdata_o[3:2] <= key_state;
				end
				default: avs_readdata_o <= '0;
			endcase
		end
	end

	assign avs_waitrequest_o = wait_q;

	// software-visible address registers
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			table_page <= '0;
			table_ea <= '0;
		end else if (wr_ack) begin
			if (ofs == `PFS_OFS_PAGE && avs_byteenable_i[0]) begin
				table_page <= avs_writedata_i[7:0];
			end
			if (ofs == `PFS_OFS_EA) begin
				if (avs_byteenable_i[0]) begin
					table_ea[7:0] <= avs_writedata_i[7:0];
				end
				if (avs_byteenable_i[1]) begin
					table_ea[15:8] <= avs_writedata_i[15:8];
				end
			end
		end
	end

	// row address follows every table access; direct writes also allowed
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			row_lo <= '0;
			row_hi <= '0;
		end else if (ack_now && (ofs == `PFS_OFS_TDATA_LO ||
			ofs == `PFS_OFS_TDATA_HI)) begin
			row_lo <= table_ea;
			row_hi <= table_page;
		end else if (wr_ack && ofs == `PFS_OFS_ROW_LO) begin
			if (avs_byteenable_i[0]) begin
				row_lo[7:0] <= avs_writedata_i[7:0];
			end
			if (avs_byteenable_i[1]) begin
				row_lo[15:8] <= avs_writedata_i[15:8];
			end
		end else if (wr_ack && ofs == `PFS_OFS_ROW_HI &&
			avs_byteenable_i[0]) begin
			row_hi <= avs_writedata_i[7:0];
		end
	end

	// unlock: any write that breaks the pair drops the key
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			key_state <= key_locked;
		end else if (wr_ack) begin
			if (ofs == `PFS_OFS_KEY &&
				avs_writedata_i[7:0] == `PFS_KEY_FIRST) begin
				key_state <= key_half;
			end else if (ofs == `PFS_OFS_KEY && key_state == key_half &&
				avs_writedata_i[7:0] == `PFS_KEY_SECOND) begin
				key_state <= key_armed;
			end else begin
				key_state <= key_locked;
			end
		end
	end

	// control register; the start bit is owned by the sequencer
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_wren <= CTRL_RST[`PFS_CTRL_WREN];
			ctrl_wrerr <= CTRL_RST[`PFS_CTRL_WRERR];
			ctrl_op <= CTRL_RST[`PFS_CTRL_OP_MSB:0];
		end else if (wr_ack && ofs == `PFS_OFS_CTRL) begin
			if (avs_byteenable_i[0]) begin
				ctrl_op <= avs_writedata_i[`PFS_CTRL_OP_MSB:0];
			end
			if (avs_byteenable_i[1]) begin
				ctrl_wren <= avs_writedata_i[`PFS_CTRL_WREN];
				// a refused start sets the error over the written value
				ctrl_wrerr <= avs_writedata_i[`PFS_CTRL_WRERR] ||
					(start_req && !start_ok);
			end
		end
	end

	// operation sequencer: start, timed stall, apply, self-clear
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			op_state <= op_idle;
			ctrl_wr <= CTRL_RST[`PFS_CTRL_WR];
			op_cnt <= '0;
			op_erase <= 1'b0;
			op_base <= '0;
			flash_busy_o <= 1'b0;
		end else begin
			case (op_state)
				op_idle: begin
					if (wr_ack && start_req && start_ok) begin
						op_state <= op_run;
						ctrl_wr <= 1'b1;
						flash_busy_o <= 1'b1;
						op_cnt <= '0;
						op_erase <= (avs_writedata_i[`PFS_CTRL_OP_MSB:0] ==
							`PFS_OP_ERASE_ROW);
						// whole row, low five word bits dropped
						op_base <= {row_word[22:5], 5'b00000};
					end
				end
				op_run: begin
					op_cnt <= op_cnt + 1'b1;
					if (op_cnt == CW'(OP_CYCLES - 1)) begin
						op_state <= op_apply;
					end
				end
				op_apply: begin
					op_state <= op_idle;
					ctrl_wr <= 1'b0;
					flash_busy_o <= 1'b0;
				end
				default: op_state <= op_idle;
			endcase
		end
	end

	// array update: one row per operation, reads stall while an operation runs
	always_ff @(posedge ref_clk_i) begin
		if (op_state == op_apply && in_range(op_base)) begin
			for (int i = 0; i < RW; i++) begin
				if (op_erase) begin
					flash_array[AW'(op_base + 23'(i))] <=
						`PFS_ERASED_WORD;
				end else begin
					// programming can only clear bits left set by erase
					flash_array[AW'(op_base + 23'(i))] <=
						flash_array[AW'(op_base + 23'(i))] &
						wr_latch[latch_of(op_base + 23'(i))];
				end
			end
		end
	end

	// staging fifo between the bus and the write latches
	pfs_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(ref_clk_i),
		.rst_i(rst_i),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(fifo_in_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data)
	);

	// each latch write spends two clocks, as fast as the bus can accept writes, so the fifo never holds more than one entry
	assign fifo_out_ready = fill_phase;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fill_phase <= 1'b0;
		end else if (fill_phase) begin
			fill_phase <= 1'b0;
		end else if (fifo_out_valid) begin
			fill_phase <= 1'b1;
		end
	end

	// latch slot comes from the panel number and the word position within its row
	always_ff @(posedge ref_clk_i) begin
		if (fill_phase && fifo_out_valid &&
			in_range(fifo_out_data[41:19])) begin
			if (fifo_out_data[18]) begin
				if (fifo_out_data[16]) begin
					wr_latch[latch_of(fifo_out_data[41:19])][23:16] <=
						fifo_out_data[7:0];
				end
			end else begin
				if (fifo_out_data[16]) begin
					wr_latch[latch_of(fifo_out_data[41:19])][7:0] <=
						fifo_out_data[7:0];
				end
				if (fifo_out_data[17]) begin
					wr_latch[latch_of(fifo_out_data[41:19])][15:8] <=
						fifo_out_data[15:8];
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: dv/pfs_core_model.sv
// bus master model standing in for the core's table and register accesses
`timescale 1ns/1ns
`default_nettype none
module pfs_core_model (
	// clock
	input wire logic clk_i,
	// avalon-mm master side
	output pfs_pkg::pfs_addr_t adr_o,
	output logic rd_o,
	output logic wr_o,
	output pfs_pkg::pfs_bus_word_t wd_o,
	output logic [3:0] be_o,
	input wire logic wait_i
);
	import pfs_pkg::*;
	initial begin
		adr_o = 6'h00;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wd_o = 32'h0000_0000;
		be_o = 4'h0;
	end
	// call right after a rising edge; returns right after the edge that follows the acknowledge
	task automatic acc(input logic w, input pfs_addr_t a,
		input pfs_bus_word_t d, input logic [3:0] b);
		rd_o <= !w;
		wr_o <= w;
		adr_o <= a;
		wd_o <= d;
		be_o <= b;
		@(posedge clk_i);
		while (wait_i !== 1'b0)
			@(posedge clk_i);
		rd_o <= 1'b0;
		wr_o <= 1'b0;
		// released lines flip so stale values are never mistaken for data
		adr_o <= ~a;
		wd_o <= ~d;
		be_o <= ~b;
		@(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// File: dv/pfs_flash_asserts.sv
// assertion checker for the flash self-write sequencer ports
`timescale 1ns/1ns
`default_nettype none
`include "pfs_consts.svh"
module pfs_flash_asserts #(
	parameter int OP_CYCLES = 20
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// register bus
	input wire pfs_pkg::pfs_addr_t avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire pfs_pkg::pfs_bus_word_t avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire pfs_pkg::pfs_bus_word_t avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// core stall
	input wire logic flash_busy_o
);
	import pfs_pkg::*;
	logic got_first;
	logic armed;
	int busy_cnt;
	wire logic wr_done = avs_write_i && !avs_waitrequest_o;
	wire logic rd_done = avs_read_i && !avs_waitrequest_o;
	wire logic key_wr = avs_address_i == `PFS_OFS_KEY;
	wire logic start_req = avs_write_i && avs_address_i == `PFS_OFS_CTRL
		&& avs_writedata_i[`PFS_CTRL_WR] && avs_writedata_i[`PFS_CTRL_WREN];
	// key progress follows completed writes, the order software sees
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			got_first <= 1'b0;
			armed <= 1'b0;
		end else if (wr_done) begin
			got_first <= key_wr && avs_writedata_i[7:0] == `PFS_KEY_FIRST;
			armed <= key_wr && got_first
				&& avs_writedata_i[7:0] == `PFS_KEY_SECOND;
		end
	end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			busy_cnt <= 0;
		else
			busy_cnt <= flash_busy_o ? busy_cnt + 1 : 0;
	end
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_launch;
		$rose(flash_busy_o);
	endsequence
	sequence s_run;
		flash_busy_o [*8];
	endsequence
	chk_wait_pulse: assert property (
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low longer than one cycle");
	chk_ack_has_req: assert property (
		!avs_waitrequest_o |-> avs_read_i || avs_write_i)
		else $error("acknowledge without a request");
	chk_busy_stalls: assert property (
		flash_busy_o && $past(flash_busy_o) |-> avs_waitrequest_o)
		else $error("access answered while an operation runs");
	chk_busy_length: assert property (
		$fell(flash_busy_o) |-> busy_cnt >= OP_CYCLES
			&& busy_cnt <= OP_CYCLES + 2)
		else $error("operation time wrong");
	chk_op_runs: assert property (
		s_launch |-> s_run ##[1:1000] !flash_busy_o)
		else $error("operation too short or never ends");
	chk_start_cause: assert property (
		s_launch |-> $past(start_req))
		else $error("operation began without a start write");
	chk_key_gate: assert property (
		s_launch |-> $past(armed))
		else $error("operation began without the unlock keys");
	chk_refused_start: assert property (
		start_req && !armed && !flash_busy_o |=> !flash_busy_o)
		else $error("locked start write ran an operation");
	chk_wr_clears: assert property (
		rd_done && avs_address_i == `PFS_OFS_CTRL
			|-> !avs_readdata_o[`PFS_CTRL_WR])
		else $error("start bit still set after operation");
	chk_key_reads_zero: assert property (
		rd_done && key_wr |-> avs_readdata_o == 32'h0000_0000)
		else $error("key register readable");
	chk_ack_bound: assert property (
		$rose(avs_read_i || avs_write_i) |-> ##[1:1000] !avs_waitrequest_o)
		else $error("access never answered");
endmodule
bind pfs_flash pfs_flash_asserts #(.OP_CYCLES(OP_CYCLES)) u_chk (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .flash_busy_o(flash_busy_o)
);
`default_nettype wire

// File: dv/tb_program_flash_self_write.sv
// self-checking bench for the program flash self-write sequencer
`timescale 1ns/1ns
`default_nettype none
`include "pfs_consts.svh"
module tb_program_flash_self_write;
	import pfs_pkg::*;
	localparam int OPC = 20;
	logic ref_clk_i;
	logic rst_i;
	pfs_addr_t adr;
	logic rd;
	logic wr;
	pfs_bus_word_t wd;
	pfs_bus_word_t rdata;
	logic [3:0] be;
	logic waitreq;
	logic busy;
	int miscompares;
	int cmp_count;
	logic [63:0] exp_q[$];
	logic [63:0] e;
	logic [23:0] img[32];
	logic [31:0] seed;
	logic [15:0] base;
	pfs_flash #(.OP_CYCLES(OPC)) uut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(waitreq), .flash_busy_o(busy));
	pfs_core_model m (.clk_i(ref_clk_i), .adr_o(adr), .rd_o(rd),
		.wr_o(wr), .wd_o(wd), .be_o(be), .wait_i(waitreq));
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic cmp(input string n, input logic [31:0] ex,
		input logic [31:0] got);
		cmp_count++;
		if (got !== ex) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, ex, got);
		end
	endtask
	task automatic wrx(input pfs_addr_t a, input logic [31:0] d,
		input logic [3:0] b);
		m.acc(1'b1, a, d, b);
	endtask
	task automatic rdx(input pfs_addr_t a, input logic [31:0] ex,
		input logic [31:0] mk);
		exp_q.push_back({mk, ex & mk});
		m.acc(1'b0, a, 32'h0000_0000, 4'hf);
	endtask
	// read data is taken only at the acknowledge edge
	always @(posedge ref_clk_i) begin
		if (rd === 1'b1 && waitreq === 1'b0) begin
			e = exp_q.pop_front();
			cmp("readdata", e[31:0], rdata & e[63:32]);
		end
	end
	task automatic launch(input logic [6:0] op);
		wrx(`PFS_OFS_KEY, {24'h0, `PFS_KEY_FIRST}, 4'h1);
		wrx(`PFS_OFS_KEY, {24'h0, `PFS_KEY_SECOND}, 4'h1);
		wrx(`PFS_OFS_CTRL, 32'h0000_c000 | op, 4'h3);
		cmp("busy", 32'h0000_0001, {31'h0, busy});
		rdx(`PFS_OFS_CTRL, 32'h0000_0000, 32'h0000_8000);
	endtask
	task automatic vrow(input logic [15:0] b, input logic ones);
		for (int i = 0; i < 32; i++) begin
			wrx(`PFS_OFS_EA, {16'h0, b + 16'(2 * i)}, 4'h3);
			rdx(`PFS_OFS_TDATA_LO, ones ? 32'h0000_ffff
				: {16'h0, img[i][15:0]}, 32'h0000_ffff);
			rdx(`PFS_OFS_TDATA_HI, ones ? 32'h0000_00ff
				: {24'h0, img[i][23:16]}, 32'h0000_00ff);
		end
	endtask
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#(40 * 40000);
		miscompares++;
		summarize();
	end
	initial begin
		miscompares = 0;
		cmp_count = 0;
		seed = 32'h60ad_20df;
		rst_i = 1'b1;
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		rdx(`PFS_OFS_CTRL, 32'h0000_0000, 32'hffff_ffff);
		rdx(6'h3c, 32'h0000_0000, 32'hffff_ffff);
		wrx(`PFS_OFS_KEY, {24'h0, `PFS_KEY_FIRST}, 4'h1);
		rdx(`PFS_OFS_KEY, 32'h0000_0000, 32'hffff_ffff);
		rdx(`PFS_OFS_STATUS, 32'h0000_0004, 32'h0000_000c);
		wrx(`PFS_OFS_PAGE, 32'h0000_0000, 4'h1);
		rdx(`PFS_OFS_STATUS, 32'h0000_0000, 32'h0000_000c);
		seed = xs(seed);
		base = {4'h0, seed[5:0], 6'h00};
		for (int k = 0; k < 2; k++) begin
			wrx(`PFS_OFS_EA, {16'h0, base + 16'(k * 64)}, 4'h3);
			rdx(`PFS_OFS_TDATA_LO, 32'h0000_0000, 32'h0000_0000);
			rdx(`PFS_OFS_ROW_LO, {16'h0, base + 16'(k * 64)},
				32'h0000_ffff);
			launch(`PFS_OP_ERASE_ROW);
			vrow(base + 16'(k * 64), 1'b1);
		end
		wrx(`PFS_OFS_EA, 32'h0000_2000, 4'h3);
		rdx(`PFS_OFS_TDATA_LO, 32'h0000_0000, 32'h0000_ffff);
		wrx(`PFS_OFS_PAGE, 32'h0000_0001, 4'h1);
		wrx(`PFS_OFS_EA, {16'h0, base}, 4'h3);
		rdx(`PFS_OFS_TDATA_LO, 32'h0000_0000, 32'h0000_ffff);
		wrx(`PFS_OFS_PAGE, 32'h0000_0000, 4'h1);
		for (int i = 0; i < 32; i++) begin
			seed = xs(seed);
			img[i] = seed[23:0];
			wrx(`PFS_OFS_EA, {16'h0, base + 16'(2 * i)}, 4'h3);
			wrx(`PFS_OFS_TDATA_LO, seed, 4'h3);
			if (i == 1) begin
				wrx(`PFS_OFS_TDATA_LO, ~seed, 4'h2);
				img[i][15:8] = ~seed[15:8];
			end
			wrx(`PFS_OFS_TDATA_HI, seed >> 16, 4'h1);
		end
		rdx(`PFS_OFS_TDATA_LO, 32'h0000_ffff, 32'h0000_ffff);
		launch(`PFS_OP_PROG_ROW);
		vrow(base, 1'b0);
		vrow(base + 16'd64, 1'b1);
		wrx(`PFS_OFS_EA, {16'h0, base}, 4'h3);
		rdx(`PFS_OFS_TDATA_LO, {16'h0, img[0][15:0]}, 32'h0000_ffff);
		// locked start: must be refused and flagged
		wrx(`PFS_OFS_CTRL, 32'h0000_c041, 4'h3);
		cmp("busy", 32'h0000_0000, {31'h0, busy});
		rdx(`PFS_OFS_CTRL, 32'h0000_2000, 32'h0000_a000);
		wrx(`PFS_OFS_CTRL, 32'h0000_0000, 4'h3);
		// unlocked but without the enable bit: still refused
		wrx(`PFS_OFS_KEY, {24'h0, `PFS_KEY_FIRST}, 4'h1);
		wrx(`PFS_OFS_KEY, {24'h0, `PFS_KEY_SECOND}, 4'h1);
		wrx(`PFS_OFS_CTRL, 32'h0000_8041, 4'h3);
		cmp("busy", 32'h0000_0000, {31'h0, busy});
		rdx(`PFS_OFS_CTRL, 32'h0000_2000, 32'h0000_e000);
		vrow(base, 1'b0);
		summarize();
	end
endmodule
`default_nettype wire
